// [hdl/acq_event_timer_result_regs.sv]
// event flags, limits, instruction delay and result words of the
// acquisition sequencer, with an APB register slave
// assumes the sequencer, converter and side events run on clk
//
// Overview of operation
// - limit low byte is eight-bit magnitude
// - limit bit 8 is the sign
// - limit bit 9 picks below or above
// - enable bits 7..0 gate each event's request
// - enable bits 10..8 pick the watched instruction
// - enable bits 15..11 pick watched queue level
// - flag 0 on limit crossing in watchdog mode
// - flags 3 and 4 on zeroing, calibration done
// - flags 5,6,7 on pause, low supply, wake
// - flags set regardless of enable bits 7..0
// - reading flags or device reset clears them
// - status bits 10..8 show current instruction
// - status bits 15..11 show queued result count mod 32
// - timer wait lasts 32 times preset plus two
// - full resolution result in bits 11..0
// - reduced result in 11..4, low nibble 1110
// - result bit 12 carries sign
// - result bits 15..13 index or sign copies
// - instruction bit 9 requests timer wait
// - instruction bit 10 selects reduced resolution
// - pause clears start, host restarts it
module acq_event_timer_result_regs (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// sequencer handshake
	input  wire acq_pkg::seq_req_t seq,
	input  wire logic             seq_done,
	output logic                  exec_go,
	output logic                  running,
	// converter results and side events
	input  wire acq_pkg::conv_t   conv,
	input  wire acq_pkg::side_ev_t side,
	// interrupt request
	output logic                  irq
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                 start;
		logic                 ext_sign;
		acq_pkg::word_t       enable;
		acq_pkg::word_t       preset;
		acq_pkg::word_t [7:0] limits;
		logic [7:0]           flags;
		logic [2:0]           index;
		acq_pkg::word_t       word;
		acq_pkg::fsm_t        fsm;
		logic [5:0]           prev_count;
		logic [31:0]          prdata;
		logic                 pslverr;
		logic [7:0]           rd_flags;
		logic                 rd_pop;
	} main_st_t;

	main_st_t       st;
	main_st_t       st_nxt;

	logic           setup;
	logic           access;
	acq_pkg::reg_sel_t sel;
	logic [7:0]     ev;
	logic [7:0]     clr;
	logic           dev_reset;
	logic           tmr_start;
	logic           tmr_done;
	logic           q_push;
	logic [15:0]    q_data;
	logic           q_pop;
	logic [15:0]    q_head;
	logic [5:0]     q_count;
	logic           q_full;
	logic           q_empty;
	logic [2:0]     lim_idx;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic acq_pkg::reg_sel_t decode(input logic [11:0] a);
		acq_pkg::reg_sel_t r;
		r = acq_pkg::R_NONE;
		if (a == acq_pkg::OFS_CONTROL) begin
			r = acq_pkg::R_CTRL;
		end else if (a == acq_pkg::OFS_EVENT_ENABLE) begin
			r = acq_pkg::R_EN;
		end else if (a == acq_pkg::OFS_DELAY_PRESET) begin
			r = acq_pkg::R_PRESET;
		end else if (a == acq_pkg::OFS_RESULT_QUEUE) begin
			r = acq_pkg::R_QUEUE;
		end else if (a == acq_pkg::OFS_EVENT_FLAGS) begin
			r = acq_pkg::R_FLAGS;
		end else if (a >= acq_pkg::OFS_LIMIT_BASE &&
			     a <= acq_pkg::OFS_LIMIT_LAST && a[1:0] == 2'h0) begin
			r = acq_pkg::R_LIMIT;
		end
		return r;
	endfunction

	// signed compare on the eight-bit view of the result
	function automatic logic crossed(input acq_pkg::word_t lim,
					 input logic sign,
					 input logic [7:0] mag8);
		logic signed [9:0] l;
		logic signed [9:0] v;
		l = $signed({2'h0, lim[7:0]});
		if (lim[acq_pkg::LIM_SIGN_BIT]) begin
			l = -l;
		end
		v = $signed({2'h0, mag8});
		if (sign) begin
			v = -v;
		end
		return lim[acq_pkg::LIM_DIR_BIT] ? (v > l) : (v < l);
	endfunction

	function automatic logic [15:0] fmt(input acq_pkg::conv_t c,
					    input logic reduced,
					    input logic ext,
					    input logic [2:0] idx);
		logic [15:0] w;
		w = 16'h0000;
		if (reduced) begin
			w[11:0] = {c.mag[11:4], acq_pkg::REDUCED_FILL};
		end else begin
			w[11:0] = c.mag;
		end
		w[acq_pkg::RES_SIGN_BIT] = c.sign;
		w[15:13] = ext ? {3{c.sign}} : idx;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// helpers

	// zero-wait slave; read data is captured at the setup edge so that
	// the access phase sees a flop, and side effects fire at access
	assign pready  = 1'b1;
	assign setup   = psel && !penable;
	assign access  = psel && penable;
	assign sel     = decode(paddr);
	assign lim_idx = paddr[4:2];

	result_queue u_queue (
		.clk       (clk),
		.rst       (rst),
		.flush     (dev_reset),
		.push      (q_push),
		.push_data (q_data),
		.pop       (q_pop),
		.head      (q_head),
		.count     (q_count),
		.full      (q_full),
		.empty     (q_empty)
	);

	delay_timer u_timer (
		.clk    (clk),
		.rst    (rst),
		.cancel (dev_reset),
		.start  (tmr_start),
		.preset (st.preset),
		.done   (tmr_done),
		.busy   ()
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt    = st;
		ev        = 8'h00;
		clr       = 8'h00;
		tmr_start = 1'b0;
		exec_go   = 1'b0;
		q_push    = 1'b0;
		q_data    = 16'h0000;
		q_pop     = 1'b0;
		dev_reset = access && pwrite && sel == acq_pkg::R_CTRL &&
			    pwdata[acq_pkg::CTRL_RESET_BIT];

		// sequencing of one instruction
		unique case (st.fsm)
			acq_pkg::S_IDLE: begin
				if (seq.arrive && st.start) begin
					st_nxt.index = seq.index;
					st_nxt.word  = seq.word;
					if (seq.index == st.enable[10:8]) begin
						ev[acq_pkg::EV_STEP] = 1'b1;
					end
					if (seq.word[acq_pkg::INS_PAUSE_BIT]) begin
						st_nxt.start = 1'b0;
						ev[acq_pkg::EV_HALT] = 1'b1;
						st_nxt.fsm = acq_pkg::S_PAUSE;
					end else if (seq.word[acq_pkg::INS_TIMER_BIT]) begin
						tmr_start  = 1'b1;
						st_nxt.fsm = acq_pkg::S_TIMER;
					end else begin
						exec_go    = 1'b1;
						st_nxt.fsm = acq_pkg::S_RUN;
					end
				end
			end
			acq_pkg::S_PAUSE: begin
				// the paused instruction waits for the host's restart
				if (st.start) begin
					if (st.word[acq_pkg::INS_TIMER_BIT]) begin
						tmr_start  = 1'b1;
						st_nxt.fsm = acq_pkg::S_TIMER;
					end else begin
						exec_go    = 1'b1;
						st_nxt.fsm = acq_pkg::S_RUN;
					end
				end
			end
			acq_pkg::S_TIMER: begin
				if (tmr_done) begin
					exec_go    = 1'b1;
					st_nxt.fsm = acq_pkg::S_RUN;
				end
			end
			acq_pkg::S_RUN: begin
				if (seq_done) begin
					st_nxt.fsm = acq_pkg::S_IDLE;
				end
			end
		endcase

		// results and watchdog compare
		if (conv.valid && st.fsm == acq_pkg::S_RUN) begin
			q_push = 1'b1;
			q_data = fmt(conv, st.word[acq_pkg::INS_RES_BIT],
				     st.ext_sign, st.index);
			if (st.word[acq_pkg::INS_WDOG_BIT] &&
			    crossed(st.limits[st.index], conv.sign,
				    conv.mag[11:4])) begin
				ev[acq_pkg::EV_LIMIT] = 1'b1;
			end
		end

		// side events
		ev[acq_pkg::EV_ZERO]  = side.zeroing_done;
		ev[acq_pkg::EV_CALIB] = side.calib_done;
		ev[acq_pkg::EV_LOWV]  = side.supply_low;
		ev[acq_pkg::EV_WAKE]  = side.wake_ready;

		// level event fires on the step that reaches the level
		st_nxt.prev_count = q_count;
		if (q_count != st.prev_count &&
		    q_count == {1'b0, st.enable[15:11]}) begin
			ev[acq_pkg::EV_LEVEL] = 1'b1;
		end

		// apb setup: capture read data and what a read will clear
		if (setup) begin
			st_nxt.pslverr  = (sel == acq_pkg::R_NONE);
			st_nxt.prdata   = 32'h00000000;
			st_nxt.rd_flags = 8'h00;
			st_nxt.rd_pop   = 1'b0;
			unique case (sel)
				acq_pkg::R_CTRL: begin
					st_nxt.prdata[acq_pkg::CTRL_START_BIT] = st.start;
					st_nxt.prdata[acq_pkg::CTRL_EXT_SIGN_BIT] =
						st.ext_sign;
				end
				acq_pkg::R_EN: begin
					st_nxt.prdata[15:0] = st.enable;
				end
				acq_pkg::R_PRESET: begin
					st_nxt.prdata[15:0] = st.preset;
				end
				acq_pkg::R_QUEUE: begin
					if (!q_empty) begin
						st_nxt.prdata[15:0] = q_head;
						st_nxt.rd_pop = !pwrite;
					end
				end
				acq_pkg::R_FLAGS: begin
					st_nxt.prdata[15:0] = {q_count[4:0],
							       st.index,
							       st.flags};
					st_nxt.rd_flags = pwrite ? 8'h00 : st.flags;
				end
				acq_pkg::R_LIMIT: begin
					st_nxt.prdata[15:0] = st.limits[lim_idx];
				end
				acq_pkg::R_NONE: begin
					st_nxt.prdata = 32'h00000000;
				end
			endcase
		end

		// apb access: writes and read side effects
		if (access && !st.pslverr) begin
			if (pwrite) begin
				unique case (sel)
					acq_pkg::R_CTRL: begin
						st_nxt.start =
							pwdata[acq_pkg::CTRL_START_BIT];
						st_nxt.ext_sign =
							pwdata[acq_pkg::CTRL_EXT_SIGN_BIT];
					end
					acq_pkg::R_EN: begin
						st_nxt.enable = pwdata[15:0];
					end
					acq_pkg::R_PRESET: begin
						st_nxt.preset = pwdata[15:0];
					end
					acq_pkg::R_LIMIT: begin
						st_nxt.limits[lim_idx] = pwdata[15:0];
					end
					acq_pkg::R_QUEUE, acq_pkg::R_FLAGS,
					acq_pkg::R_NONE: begin
						st_nxt.start = st_nxt.start;
					end
				endcase
			end else begin
				// only the bits that were reported are cleared
				clr   = st.rd_flags;
				q_pop = st.rd_pop;
			end
		end

		// flags: a new event wins over a clear in the same cycle
		st_nxt.flags = (st.flags & ~clr) | ev;
		if (dev_reset) begin
			st_nxt.flags = ev;
			st_nxt.fsm   = acq_pkg::S_IDLE;
			st_nxt.start = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st        <= '0;
			st.fsm    <= acq_pkg::S_IDLE;
			st.enable <= acq_pkg::RST_WORD;
			st.preset <= acq_pkg::RST_WORD;
		end else begin
			st <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata  = st.prdata;
	assign pslverr = st.pslverr && access;
	assign running = st.start;
	assign irq     = |(st.flags & st.enable[7:0]);

endmodule // acq_event_timer_result_regs

// [hdl/acq_pkg.sv]
// shared constants and carrier types of the acquisition event block
// assumes a single 25 MHz clock and an APB master with 32-bit data
package acq_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [11:0] OFS_CONTROL      = 12'h000;
	localparam logic [11:0] OFS_EVENT_ENABLE = 12'h004;
	localparam logic [11:0] OFS_DELAY_PRESET = 12'h008;
	localparam logic [11:0] OFS_RESULT_QUEUE = 12'h00C;
	localparam logic [11:0] OFS_EVENT_FLAGS  = 12'h010;
	localparam logic [11:0] OFS_LIMIT_BASE   = 12'h020;
	localparam logic [11:0] OFS_LIMIT_LAST   = 12'h03C;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_START_BIT    = 0;
	localparam int CTRL_RESET_BIT    = 1;
	localparam int CTRL_EXT_SIGN_BIT = 5;
	localparam int LIM_SIGN_BIT      = 8;
	localparam int LIM_DIR_BIT       = 9;
	localparam int EN_STEP_LSB       = 8;
	localparam int EN_LEVEL_LSB      = 11;
	localparam int INS_PAUSE_BIT     = 1;
	localparam int INS_TIMER_BIT     = 9;
	localparam int INS_RES_BIT       = 10;
	localparam int INS_WDOG_BIT      = 11;
	localparam int RES_SIGN_BIT      = 12;

	// event bit numbers
	localparam int EV_LIMIT = 0;
	localparam int EV_STEP  = 1;
	localparam int EV_LEVEL = 2;
	localparam int EV_ZERO  = 3;
	localparam int EV_CALIB = 4;
	localparam int EV_HALT  = 5;
	localparam int EV_LOWV  = 6;
	localparam int EV_WAKE  = 7;

	////////////////////////////////////////////////////////////////////////
	// values and timing
	localparam logic [3:0]  REDUCED_FILL = 4'hE;
	localparam logic [21:0] TIMER_MULT   = 22'h000020;
	localparam logic [21:0] TIMER_EXTRA  = 22'h000002;
	localparam int          QUEUE_DEPTH  = 32;
	localparam logic [15:0] RST_WORD     = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef logic [15:0] word_t;

	typedef struct packed {
		logic       arrive;
		logic [2:0] index;
		word_t      word;
	} seq_req_t;

	typedef struct packed {
		logic        valid;
		logic        sign;
		logic [11:0] mag;
	} conv_t;

	typedef struct packed {
		logic zeroing_done;
		logic calib_done;
		logic supply_low;
		logic wake_ready;
	} side_ev_t;

	typedef enum logic [1:0] {
		S_IDLE  = 2'h0,
		S_PAUSE = 2'h1,
		S_TIMER = 2'h3,
		S_RUN   = 2'h2
	} fsm_t;

	typedef enum logic [2:0] {
		R_CTRL, R_EN, R_PRESET, R_QUEUE, R_FLAGS, R_LIMIT, R_NONE
	} reg_sel_t;

endpackage

// [hdl/delay_timer.sv]
// holds off an instruction for 32 x preset + 2 clock cycles
// assumes start is a one-cycle pulse from the event block
module delay_timer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control
	input  wire logic        cancel,
	input  wire logic        start,
	input  wire logic [15:0] preset,
	// status
	output logic             done,
	output logic             busy
);

	typedef struct packed {
		logic [21:0] cnt;
	} tmr_st_t;

	tmr_st_t st;
	tmr_st_t st_nxt;

	localparam logic [21:0] TIMER_MULT_L  = acq_pkg::TIMER_MULT;
	localparam logic [21:0] TIMER_EXTRA_L = acq_pkg::TIMER_EXTRA;

	always_comb begin
		st_nxt = st;
		if (cancel) begin
			st_nxt.cnt = 22'h000000;
		end else if (start) begin
			st_nxt.cnt = 22'(preset) * TIMER_MULT_L + TIMER_EXTRA_L;
		end else if (st.cnt != 22'h000000) begin
			st_nxt.cnt = st.cnt - 22'h000001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= st_nxt;
		end
	end

	// done lands exactly the programmed number of cycles after start
	assign done = (st.cnt == 22'h000001);
	assign busy = (st.cnt != 22'h000000);

endmodule // delay_timer

// [hdl/result_queue.sv]
// 32-word queue of formatted conversion results
// assumes pop is only asked while not empty; a push when full is dropped
module result_queue (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// control
	input  wire logic        flush,
	input  wire logic        push,
	input  wire logic [15:0] push_data,
	input  wire logic        pop,
	// status
	output logic [15:0]      head,
	output logic [5:0]       count,
	output logic             full,
	output logic             empty
);

	typedef struct packed {
		logic [31:0][15:0] mem;
		logic [4:0]        wr_ptr;
		logic [4:0]        rd_ptr;
		logic [5:0]        count;
	} q_st_t;

	q_st_t st;
	q_st_t st_nxt;
	logic  do_push;
	logic  do_pop;

	always_comb begin
		st_nxt  = st;
		do_push = push && !full;
		do_pop  = pop && !empty;
		if (do_push) begin
			st_nxt.mem[st.wr_ptr] = push_data;
			st_nxt.wr_ptr = st.wr_ptr + 5'h01;
		end
		if (do_pop) begin
			st_nxt.rd_ptr = st.rd_ptr + 5'h01;
		end
		st_nxt.count = st.count + 6'(do_push) - 6'(do_pop);
		if (flush) begin
			st_nxt.wr_ptr = 5'h00;
			st_nxt.rd_ptr = 5'h00;
			st_nxt.count  = 6'h00;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= st_nxt;
		end
	end

	assign head  = st.mem[st.rd_ptr];
	assign count = st.count;
	assign full  = (st.count == 6'(acq_pkg::QUEUE_DEPTH));
	assign empty = (st.count == 6'h00);

endmodule // result_queue

// [verif/acq_event_sva.sv]
// port-level assertions for the acquisition event block
// assumes one clock, async high reset and a zero-wait apb master
module acq_event_sva (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// apb slave
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// sequencer, converter, side events
	input wire acq_pkg::seq_req_t seq,
	input wire logic              seq_done,
	input wire logic              exec_go,
	input wire logic              running,
	input wire acq_pkg::conv_t    conv,
	input wire acq_pkg::side_ev_t side,
	// interrupt request
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        wr;
	logic [15:0] en_r;
	logic [15:0] pre_r;
	int          wait_r;
	int          quiet_r;
	assign wr = psel && penable && pwrite;

	////////////////////////////////////////////////////////////////////////
	// shadows of enable and preset, wait length, quiet span before a read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_r <= acq_pkg::RST_WORD;
			pre_r <= acq_pkg::RST_WORD;
			wait_r <= 0;
			quiet_r <= 0;
		end else begin
			if (wr && paddr == acq_pkg::OFS_EVENT_ENABLE)
				en_r <= pwdata[15:0];
			if (wr && paddr == acq_pkg::OFS_DELAY_PRESET)
				pre_r <= pwdata[15:0];
			if (exec_go)
				wait_r <= 0;
			else if (seq.arrive && running && seq.word[9] && !seq.word[1])
				wait_r <= 1;
			else if (wait_r != 0)
				wait_r <= wait_r + 1;
			// any event can refill a flag, so clear checks need calm
			if (side != '0 || conv.valid || seq.arrive || seq_done || wr)
				quiet_r <= 0;
			else if (quiet_r < 8)
				quiet_r <= quiet_r + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_timer;
		exec_go && wait_r != 0 |-> wait_r == 32 * pre_r + 2;
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer wait length wrong");
	property p_direct;
		seq.arrive && running && !seq.word[1] && !seq.word[9] |-> exec_go;
	endproperty
	a_direct: assert property (p_direct)
		else $error("plain instruction not started at once");
	property p_pause;
		seq.arrive && running && seq.word[1] |-> !exec_go ##1 !running;
	endproperty
	a_pause: assert property (p_pause)
		else $error("pause did not stop the sequence");
	property p_go_run;
		exec_go |-> running;
	endproperty
	a_go_run: assert property (p_go_run)
		else $error("execution while start is clear");
	property p_en;
		en_r[7:0] == 8'h00 && $past(en_r[7:0]) == 8'h00 |-> !irq;
	endproperty
	a_en: assert property (p_en)
		else $error("request without any enable");
	property p_step;
		seq.arrive && running && en_r[1] && seq.index == en_r[10:8]
			|-> ##[1:2] irq;
	endproperty
	a_step: assert property (p_step)
		else $error("watched instruction raised no request");
	property p_side;
		side.zeroing_done && en_r[3] |-> ##[1:2] irq;
	endproperty
	a_side: assert property (p_side)
		else $error("zeroing done raised no request");
	property p_rdclr;
		psel && penable && !pwrite && paddr == acq_pkg::OFS_EVENT_FLAGS
			&& quiet_r >= 4 |=> ##1 !irq;
	endproperty
	a_rdclr: assert property (p_rdclr)
		else $error("flag read left request up");
	property p_devrst;
		wr && paddr == acq_pkg::OFS_CONTROL && pwdata[1] && quiet_r >= 4
			|=> !running ##1 !irq;
	endproperty
	a_devrst: assert property (p_devrst)
		else $error("device reset left state behind");

	c_timer: cover property (exec_go && wait_r != 0);
	c_pause: cover property (seq.arrive && seq.word[1]);
	c_err: cover property (pslverr);
endmodule // acq_event_sva

bind acq_event_timer_result_regs acq_event_sva u_sva (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .seq(seq), .seq_done(seq_done),
	.exec_go(exec_go), .running(running), .conv(conv), .side(side),
	.irq(irq)
);

// [verif/seq_model.sv]
// sequencer and converter model facing the event block
// assumes the caller offers an instruction only while the block is idle
module seq_model (
	// clock
	input  wire logic         clk,
	// from the block
	input  wire logic         exec_go,
	// to the block
	output acq_pkg::seq_req_t seq,
	output logic              seq_done,
	output acq_pkg::conv_t    conv
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		seq = '0;
		seq_done = 1'b0;
		conv = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// offer, wait for go, one conversion, done; n counts edges to go
	task automatic run(input logic [2:0] idx, input acq_pkg::word_t w,
			input logic sg, input logic [11:0] m, output int n);
		n = 0;
		@(posedge clk);
		seq <= '{1'b1, idx, w};
		do begin
			@(posedge clk);
			// idle fields toggle so a stale latch cannot pass
			seq <= '{1'b0, ~idx, ~w};
			n++;
		end while (exec_go !== 1'b1 && n < 3000);
		conv <= '{1'b1, sg, m};
		@(posedge clk);
		conv <= '{1'b0, ~sg, ~m};
		seq_done <= 1'b1;
		@(posedge clk);
		seq_done <= 1'b0;
	endtask
endmodule // seq_model

// [verif/acq_event_timer_result_regs_test.sv]
// self-checking bench for the acquisition event block
// assumes zero-wait apb and the sequencer model beside the block
`define CHK(a, b) \
	begin \
		n_checks++; \
		if ((a) !== (b)) begin \
			failures++; \
			$display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); \
		end \
	end
module acq_event_timer_result_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk, rst, psel, penable, pwrite, err;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, d;
	logic              pready, pslverr, seq_done, exec_go, running, irq;
	acq_pkg::seq_req_t seq;
	acq_pkg::conv_t    conv;
	acq_pkg::side_ev_t side;
	int                failures, n_checks, n;
	logic [15:0]       lw [4] = '{16'h0240, 16'h0240, 16'h0140, 16'h0140};
	logic              lsg [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic [11:0]       lmg [4] = '{12'h500, 12'h300, 12'h100, 12'h500};
	logic              lex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
	logic [7:0]        ev [4] = '{8'h08, 8'h10, 8'h40, 8'h80};

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	acq_event_timer_result_regs u_dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .seq(seq), .seq_done(seq_done),
		.exec_go(exec_go), .running(running), .conv(conv), .side(side),
		.irq(irq));
	seq_model u_seq (.clk(clk), .exec_go(exec_go), .seq(seq),
		.seq_done(seq_done), .conv(conv));

	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#800000;
		failures++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		failures = 0;
		n_checks = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		side = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(acq_pkg::OFS_EVENT_FLAGS);
		`CHK(d, 32'h00000000);
		rd(12'hFFC);
		`CHK(err, 1'b1);
		apb(1'b1, acq_pkg::OFS_EVENT_ENABLE, 32'h00000A00);
		rd(acq_pkg::OFS_EVENT_ENABLE);
		`CHK(d, 32'h00000A00);
		apb(1'b1, acq_pkg::OFS_DELAY_PRESET, 32'h00000002);
		rd(acq_pkg::OFS_DELAY_PRESET);
		`CHK(d, 32'h00000002);
		apb(1'b1, acq_pkg::OFS_CONTROL, 32'h00000001);
		// flags rise with enables clear, and show count and level
		u_seq.run(3'h2, 16'h0000, 1'b0, 12'h123, n);
		`CHK(n, 1);
		repeat (3) @(posedge clk);
		`CHK(irq, 1'b0);
		rd(acq_pkg::OFS_EVENT_FLAGS);
		`CHK(d[7:0], 8'h06);
		`CHK(d[15:11], 5'h01);
		rd(acq_pkg::OFS_EVENT_FLAGS);
		`CHK(d[7:0], 8'h00);
		apb(1'b1, acq_pkg::OFS_EVENT_ENABLE, 32'h00000A02);
		u_seq.run(3'h2, 16'h0000, 1'b1, 12'hABC, n);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1);
		rd(acq_pkg::OFS_EVENT_FLAGS);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		`CHK(d, 32'h00004123);
		rd(acq_pkg::OFS_EVENT_FLAGS);
		`CHK(d[15:11], 5'h01);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		`CHK(d, 32'h00005ABC);
		// reduced resolution with sign copies on top
		apb(1'b1, acq_pkg::OFS_CONTROL, 32'h00000021);
		u_seq.run(3'h5, 16'h0400, 1'b1, 12'h7F3, n);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		`CHK(d, 32'h0000F7FE);
		// timer wait, index shown while waiting
		fork
			u_seq.run(3'h6, 16'h0200, 1'b0, 12'h010, n);
			begin
				repeat (20) @(posedge clk);
				rd(acq_pkg::OFS_EVENT_FLAGS);
				`CHK(d[10:8], 3'h6);
			end
		join
		`CHK(n, 32 * 2 + 3);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		`CHK(d, 32'h00000010);
		// pause stops the sequence until start is written again
		fork
			u_seq.run(3'h1, 16'h0002, 1'b0, 12'h020, n);
			begin
				repeat (5) @(posedge clk);
				`CHK(running, 1'b0);
				rd(acq_pkg::OFS_EVENT_FLAGS);
				`CHK(d[5], 1'b1);
				apb(1'b1, acq_pkg::OFS_CONTROL, 32'h00000021);
			end
		join
		`CHK(n < 3000, 1'b1);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		// limit direction and sign, both sides of the threshold
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, acq_pkg::OFS_LIMIT_BASE + 12'h00C, {16'h0000, lw[i]});
			u_seq.run(3'h3, 16'h0800, lsg[i], lmg[i], n);
			`CHK(n, 1);
			rd(acq_pkg::OFS_EVENT_FLAGS);
			`CHK(d[0], lex[i]);
			rd(acq_pkg::OFS_RESULT_QUEUE);
		end
		rd(acq_pkg::OFS_LIMIT_BASE + 12'h00C);
		`CHK(d, 32'h00000140);
		// side events, each on its own flag; level 1 so the later flush
		// to an empty queue does not raise the level flag again
		apb(1'b1, acq_pkg::OFS_EVENT_ENABLE, 32'h00000808);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			side <= 4'h8 >> i;
			@(posedge clk);
			side <= '0;
			repeat (2) @(posedge clk);
			rd(acq_pkg::OFS_EVENT_FLAGS);
			`CHK(d[7:0], ev[i]);
		end
		// device reset empties queue and flags
		u_seq.run(3'h0, 16'h0000, 1'b0, 12'h001, n);
		`CHK(n, 1);
		@(posedge clk);
		side <= 4'hF;
		@(posedge clk);
		side <= '0;
		// calm span so the reset check in the checker is armed
		repeat (4) @(posedge clk);
		apb(1'b1, acq_pkg::OFS_CONTROL, 32'h00000002);
		rd(acq_pkg::OFS_EVENT_FLAGS);
		`CHK(d[7:0], 8'h00);
		`CHK(d[15:11], 5'h00);
		`CHK(running, 1'b0);
		rd(acq_pkg::OFS_RESULT_QUEUE);
		`CHK(d, 32'h00000000);
		report_and_stop();
	end
endmodule // acq_event_timer_result_regs_test
